// ---- async_serial_transceiver.sv ----
// Purpose: Full-duplex asynchronous serial transceiver with an APB register slave.
// Assumes: One clock pclk; the receive pin is asynchronous and synchronised here.
// Notes: Each access has one wait state; unmapped addresses answer with pslverr.
`timescale 1ns/1ps
`include "uart_regs.svh"
module async_serial_transceiver #(
    parameter int CLK_HZ = `SYS_CLK_HZ,
    parameter int BASE_BAUD = `FASTEST_BAUD
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_rx,
    output logic serial_tx,
    output logic serial_irq
);
    uart_pkg::uart_state_t st_reg;
    uart_pkg::uart_state_t st_next;

    logic tick;
    logic rx_level;
    logic [1:0] mode;
    logic [3:0] last_bit;
    logic par_on;
    logic [5:0] idx;
    logic hit;
    logic [7:0] rd_value;
    logic access;
    logic commit;
    logic wr;
    logic rd;
    logic bit_end;
    logic bit_val;
    logic [8:0] rx_word;
    logic rx_load;
    logic ev_tx_empty;
    logic ev_perr;
    logic ev_ovr;
    logic ev_ferr;
    logic [8:0] tx_word;

    // Shared bit timing for both directions.
    baud_tick #(
        .CLK_HZ(CLK_HZ),
        .BASE_BAUD(BASE_BAUD),
        .OVS(`OVS_RATE)
    ) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .sel(st_reg.tx_ctrl[`TXC_BAUD_HI:`TXC_BAUD_LO]),
        .tick(tick)
    );

    line_sync u_rx_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(serial_rx),
        .level(rx_level)
    );

    // Frame shape from the mode field; mode 3 carries nine bits and never parity.
    always_comb begin
        mode = st_reg.tx_ctrl[`TXC_MODE_HI:`TXC_MODE_LO];
        if (mode == `MODE_7BIT) begin
            last_bit = `LAST_BIT_7;
        end else if (mode == `MODE_9BIT) begin
            last_bit = `LAST_BIT_9;
        end else begin
            last_bit = `LAST_BIT_8;
        end
        par_on = st_reg.rx_status[`RXS_PAR_EN] && (mode != `MODE_9BIT);
    end

    // Address decode: word aligned, index compared against the map.
    always_comb begin
        idx = paddr[7:2];
        hit = (paddr[1:0] == 2'h0);
        rd_value = 8'h00;
        if (idx == `IDX_IRQ_FLAGS) begin
            rd_value = st_reg.irq_flags & `IRQ_USED_MASK;
        end else if (idx == `IDX_IRQ_MASK) begin
            rd_value = st_reg.irq_mask & `IRQ_USED_MASK;
        end else if (idx == `IDX_TX_CONTROL) begin
            rd_value = st_reg.tx_ctrl;
            rd_value[`TXC_BUF_STATUS] = st_reg.tx_full;
        end else if (idx == `IDX_LINE_EXTRA) begin
            rd_value = st_reg.line_extra & `LCX_WRITE_MASK;
        end else if (idx == `IDX_RX_STATUS) begin
            rd_value = st_reg.rx_status;
        end else if (idx == `IDX_RX_DATA) begin
            rd_value = st_reg.rx_data;
        end else if (idx == `IDX_TX_DATA) begin
            rd_value = st_reg.tx_data;
        end else begin
            hit = 1'b0;
        end
        access = psel && penable && !st_reg.pready;
        commit = psel && penable && st_reg.pready && hit;
        wr = commit && pwrite;
        rd = commit && !pwrite;
    end

    // Next-state logic for bus, transmitter and receiver.
    always_comb begin
        st_next = st_reg;
        ev_tx_empty = 1'b0;
        ev_perr = 1'b0;
        ev_ovr = 1'b0;
        ev_ferr = 1'b0;
        rx_load = 1'b0;
        bit_end = 1'b0;
        bit_val = 1'b0;
        rx_word = 9'h000;
        tx_word = {st_reg.tx_ctrl[`TXC_NINTH], st_reg.tx_data};

        // Bus answer: data is registered on the same edge that raises pready.
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (access) begin
            st_next.pready = 1'b1;
            st_next.prdata = rd_value;
            st_next.pslverr = !hit;
        end

        // Transmitter: hold buffer moves to the shifter only on a tick, so bits stay whole.
        if (tick) begin
            st_next.tx_ovs = st_reg.tx_ovs + 4'h1;
            case (st_reg.tx_phase)
                uart_pkg::TX_IDLE: begin
                    st_next.tx_line = 1'b1;
                    st_next.tx_ovs = 4'h0;
                    if (st_reg.tx_ctrl[`TXC_ENABLE] && st_reg.tx_full) begin
                        st_next.tx_full = 1'b0;
                        st_next.tx_shift = tx_word;
                        st_next.tx_phase = uart_pkg::TX_START;
                        st_next.tx_line = 1'b0;
                    end
                end
                uart_pkg::TX_START: begin
                    if (st_reg.tx_ovs == `OVS_LAST) begin
                        st_next.tx_phase = uart_pkg::TX_DATA;
                        st_next.tx_bit = 4'h0;
                        st_next.tx_line = st_reg.tx_shift[0];
                        st_next.tx_par = 1'b0;
                    end
                end
                uart_pkg::TX_DATA: begin
                    if (st_reg.tx_ovs == `OVS_LAST) begin
                        st_next.tx_par = st_reg.tx_par ^ st_reg.tx_shift[0];
                        st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]};
                        st_next.tx_bit = st_reg.tx_bit + 4'h1;
                        st_next.tx_line = st_reg.tx_shift[1];
                        if (st_reg.tx_bit == last_bit) begin
                            if (par_on) begin
                                st_next.tx_phase = uart_pkg::TX_PARITY;
                                // Even sense makes the total count of ones even.
                                st_next.tx_line = (st_reg.tx_par ^ st_reg.tx_shift[0])
                                    ^ !st_reg.rx_status[`RXS_EVEN];
                            end else begin
                                st_next.tx_phase = uart_pkg::TX_STOP;
                                st_next.tx_line = 1'b1;
                            end
                        end
                    end
                end
                uart_pkg::TX_PARITY: begin
                    if (st_reg.tx_ovs == `OVS_LAST) begin
                        st_next.tx_phase = uart_pkg::TX_STOP;
                        st_next.tx_line = 1'b1;
                    end
                end
                uart_pkg::TX_STOP: begin
                    if (st_reg.tx_ovs == `OVS_LAST) begin
                        ev_tx_empty = 1'b1;
                        // A waiting character starts at once, so back-to-back frames have no gap.
                        if (st_reg.tx_ctrl[`TXC_ENABLE] && st_reg.tx_full) begin
                            st_next.tx_full = 1'b0;
                            st_next.tx_shift = tx_word;
                            st_next.tx_phase = uart_pkg::TX_START;
                            st_next.tx_line = 1'b0;
                        end else begin
                            st_next.tx_phase = uart_pkg::TX_IDLE;
                            st_next.tx_line = 1'b1;
                        end
                    end
                end
                default: begin
                    st_next.tx_phase = uart_pkg::TX_IDLE;
                end
            endcase
        end

        // Receiver: edge search in idle, then three votes around the middle of each bit.
        st_next.rx_prev = rx_level;
        if (st_reg.rx_phase == uart_pkg::RX_IDLE) begin
            st_next.rx_ovs = 4'h0;
            st_next.rx_votes = 2'h0;
            if (st_reg.rx_status[`RXS_ENABLE] && st_reg.rx_prev && !rx_level) begin
                st_next.rx_phase = uart_pkg::RX_START;
            end
        end else if (tick) begin
            st_next.rx_ovs = st_reg.rx_ovs + 4'h1;
            if (st_reg.rx_ovs == `OVS_VOTE_A || st_reg.rx_ovs == `OVS_VOTE_B
                    || st_reg.rx_ovs == `OVS_VOTE_C) begin
                st_next.rx_votes = st_reg.rx_votes + {1'b0, rx_level};
            end
            if (st_reg.rx_ovs == `OVS_LAST) begin
                bit_end = 1'b1;
                bit_val = (st_reg.rx_votes >= `VOTE_MAJORITY);
                st_next.rx_votes = 2'h0;
            end
        end

        if (bit_end) begin
            case (st_reg.rx_phase)
                uart_pkg::RX_START: begin
                    // Two or three zero votes accept the start; otherwise it was a glitch.
                    if (!bit_val) begin
                        st_next.rx_phase = uart_pkg::RX_DATA;
                        st_next.rx_bit = 4'h0;
                        st_next.rx_shift = 9'h000;
                    end else begin
                        st_next.rx_phase = uart_pkg::RX_IDLE;
                    end
                end
                uart_pkg::RX_DATA: begin
                    st_next.rx_shift[st_reg.rx_bit] = bit_val;
                    st_next.rx_bit = st_reg.rx_bit + 4'h1;
                    if (st_reg.rx_bit == last_bit) begin
                        st_next.rx_phase = par_on ? uart_pkg::RX_PARITY : uart_pkg::RX_STOP;
                    end
                end
                uart_pkg::RX_PARITY: begin
                    st_next.rx_par = bit_val;
                    st_next.rx_phase = uart_pkg::RX_STOP;
                end
                uart_pkg::RX_STOP: begin
                    rx_load = 1'b1;
                    rx_word = st_reg.rx_shift;
                    ev_ferr = !bit_val;
                    ev_perr = par_on && ((^st_reg.rx_shift ^ st_reg.rx_par)
                        != !st_reg.rx_status[`RXS_EVEN]);
                    ev_ovr = st_reg.rx_status[`RXS_FULL];
                    st_next.rx_phase = uart_pkg::RX_IDLE;
                end
                default: begin
                    st_next.rx_phase = uart_pkg::RX_IDLE;
                end
            endcase
        end

        // A load between data capture and completion must not be cleared by that read.
        if (rx_load && access) begin
            st_next.rx_fresh = 1'b1;
        end else if (psel && penable && st_reg.pready) begin
            st_next.rx_fresh = 1'b0;
        end

        // Software writes and read side effects.
        if (wr) begin
            if (idx == `IDX_IRQ_FLAGS) begin
                st_next.irq_flags = pwdata[7:0] & `IRQ_USED_MASK;
            end else if (idx == `IDX_IRQ_MASK) begin
                st_next.irq_mask = pwdata[7:0] & `IRQ_USED_MASK;
            end else if (idx == `IDX_TX_CONTROL) begin
                st_next.tx_ctrl = pwdata[7:0];
                st_next.tx_ctrl[`TXC_BUF_STATUS] = 1'b0;
            end else if (idx == `IDX_LINE_EXTRA) begin
                st_next.line_extra = pwdata[7:0] & `LCX_WRITE_MASK;
            end else if (idx == `IDX_RX_STATUS) begin
                st_next.rx_status[`RXS_ENABLE] = pwdata[`RXS_ENABLE];
                st_next.rx_status[`RXS_EVEN] = pwdata[`RXS_EVEN];
                st_next.rx_status[`RXS_PAR_EN] = pwdata[`RXS_PAR_EN];
                // Error bits are cleared by writing zero; writing one keeps them.
                st_next.rx_status[`RXS_PAR_ERR] = st_reg.rx_status[`RXS_PAR_ERR]
                    & pwdata[`RXS_PAR_ERR];
                st_next.rx_status[`RXS_OVR_ERR] = st_reg.rx_status[`RXS_OVR_ERR]
                    & pwdata[`RXS_OVR_ERR];
                st_next.rx_status[`RXS_FRM_ERR] = st_reg.rx_status[`RXS_FRM_ERR]
                    & pwdata[`RXS_FRM_ERR];
            end else if (idx == `IDX_TX_DATA) begin
                st_next.tx_data = pwdata[7:0];
                st_next.tx_full = 1'b1;
            end
        end
        if (rd && idx == `IDX_RX_DATA && !st_reg.rx_fresh) begin
            st_next.rx_status[`RXS_FULL] = 1'b0;
        end

        // Hardware sets come last so an event in a clearing cycle wins.
        if (rx_load) begin
            // On overrun the unread character is kept and the new one is dropped.
            if (!ev_ovr) begin
                st_next.rx_data = (mode == `MODE_7BIT) ? {1'b0, rx_word[6:0]} : rx_word[7:0];
                st_next.rx_status[`RXS_NINTH] = (mode == `MODE_9BIT) && rx_word[8];
            end
            st_next.rx_status[`RXS_FULL] = 1'b1;
            st_next.irq_flags[`IRQ_RX_FULL] = 1'b1;
        end
        if (ev_perr) begin
            st_next.rx_status[`RXS_PAR_ERR] = 1'b1;
        end
        if (ev_ovr) begin
            st_next.rx_status[`RXS_OVR_ERR] = 1'b1;
        end
        if (ev_ferr) begin
            st_next.rx_status[`RXS_FRM_ERR] = 1'b1;
        end
        // Uncleared error bits re-raise the error flag with each new character.
        if (rx_load && (|st_next.rx_status[`RXS_PAR_ERR:`RXS_FRM_ERR])) begin
            st_next.irq_flags[`IRQ_ERR] = 1'b1;
        end
        if (ev_tx_empty) begin
            st_next.irq_flags[`IRQ_TX_EMPTY] = 1'b1;
        end

        // Interrupt request from flags gated by their enables.
        st_next.irq = |(st_next.irq_flags & st_next.irq_mask & `IRQ_USED_MASK);
    end

    // All state registered together; line idles at mark from reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.irq_flags <= `REG_RESET;
            st_reg.irq_mask <= `REG_RESET;
            st_reg.tx_ctrl <= `REG_RESET;
            st_reg.line_extra <= `REG_RESET;
            st_reg.rx_status <= `REG_RESET;
            st_reg.tx_phase <= uart_pkg::TX_IDLE;
            st_reg.rx_phase <= uart_pkg::RX_IDLE;
            st_reg.tx_line <= 1'b1;
            st_reg.rx_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = {24'h000000, st_reg.prdata};
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign serial_tx = st_reg.tx_line;
    assign serial_irq = st_reg.irq;
endmodule // async_serial_transceiver

// ---- baud_tick.sv ----
// Purpose: Oversampling tick for both transmit and receive bit timing.
// Assumes: pclk at CLK_HZ; tick rate is OVS ticks per bit at BASE_BAUD divided by two to sel.
// Notes: A change of sel takes effect at once; the running count is compared with the new limit.
`timescale 1ns/1ps
`include "uart_regs.svh"
module baud_tick #(
    parameter int CLK_HZ = `SYS_CLK_HZ,
    parameter int BASE_BAUD = `FASTEST_BAUD,
    parameter int OVS = `OVS_RATE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] sel,
    output logic tick
);
    localparam int BASE_DIV = CLK_HZ / (BASE_BAUD * OVS);

    // The slowest code shifts the base divider left by seven; it must fit the counter.
    if (BASE_DIV < 1 || (BASE_DIV * 128) > 65536) begin : g_bad_div
        $error("baud_tick: divider out of range");
    end

    uart_pkg::baud_state_t st_reg;
    uart_pkg::baud_state_t st_next;
    logic [15:0] limit;

    // One-cycle enable each time the counter wraps.
    always_comb begin
        limit = 16'((BASE_DIV << sel) - 1);
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.count >= limit) begin
            st_next.count = 16'h0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.count = st_reg.count + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule // baud_tick

// ---- line_sync.sv ----
// Purpose: Two-flop synchroniser for the asynchronous receive pin.
// Assumes: The pin is driven from outside the pclk domain.
// Notes: Only the second flop is visible; the first is read by nothing else.
`timescale 1ns/1ps
module line_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    uart_pkg::sync_state_t st_reg;
    uart_pkg::sync_state_t st_next;

    // Idle level is high, so reset to mark and avoid a false start after reset.
    always_comb begin
        st_next = st_reg;
        st_next.meta = pin;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{meta: 1'b1, stable: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.stable;
endmodule // line_sync

// ---- serial_peer.sv ----
// Purpose: Remote serial device sending frames on the receive pin.
// Assumes: Frame inputs stay stable while busy.
// Notes: The line rests at mark between frames.
`timescale 1ns/1ps
module serial_peer #(
    parameter int BIT_CLKS = 16
) (
    input wire logic pclk,
    input wire logic go,
    input wire logic [11:0] frame,
    input wire logic [3:0] nbits,
    output logic line,
    output logic busy
);
    initial line = 1'b1;
    initial busy = 1'b0;
    // Bits leave LSB first, one bit time each, then the line goes back high.
    always @(posedge pclk) begin
        if (go) begin
            busy <= 1'b1;
            for (int i = 0; i < nbits; i++) begin
                line <= frame[i];
                repeat (BIT_CLKS) @(posedge pclk);
            end
            line <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule // serial_peer

// ---- test_async_serial_transceiver.sv ----
// Purpose: Register-level test of the transceiver with a remote peer.
// Assumes: 16 clocks per bit at baud select 0.
// Notes: Expected words come from the frame layout.
`timescale 1ns/1ps
module test_async_serial_transceiver;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00, q;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, serial_rx, serial_tx, serial_irq, busy, err;
    logic [11:0] frame = 12'hfff;
    logic [3:0] nbits = 4'h0;
    logic [7:0] ctl [3] = '{8'h41, 8'h21, 8'he1};
    logic [7:0] rxs [3] = '{8'h00, 8'h60, 8'h00};
    logic [7:0] txd [3] = '{8'ha5, 8'h13, 8'h5a};
    logic [10:0] txb [3] = '{{2'h3, 8'ha5, 1'b0}, {3'h7, 7'h13, 1'b0}, {2'h3, 8'h5a, 1'b0}};
    int txn [3] = '{10, 10, 11};
    int bad_count = 0, total_checks = 0;
    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;
    async_serial_transceiver #(.BASE_BAUD(6250000)) dut (.*);
    serial_peer peer (.pclk(pclk), .go(go), .frame(frame), .nbits(nbits), .line(serial_rx),
        .busy(busy));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // A wait that used up its bound ends the run as a failure.
    task automatic guard(input logic stuck);
        if (stuck !== 1'b0) begin
            bad_count++;
            tally_and_finish;
        end
    endtask
    // APB transfer held until pready is sampled high, then a short idle gap.
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        guard(pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        apb(1'b0, a, 8'h00);
        check({24'h0, q}, {24'h0, want});
    endtask
    // The peer sends start, data, parity and stop; then the receiver settles.
    task automatic send(input logic [7:0] d, input logic par, input logic stop);
        int k;
        frame <= {1'b1, stop, par, d, 1'b0};
        nbits <= 4'hb;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (busy !== 1'b0 && k < 400);
        guard(busy);
        repeat (8) @(posedge pclk);
    endtask
    // Find the start edge, then sample each bit in its middle.
    task automatic expect_tx(input logic [10:0] bits, input int n);
        int k;
        k = 0;
        while (serial_tx !== 1'b0 && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        guard(serial_tx !== 1'b0);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            check({31'h0, serial_tx}, {31'h0, bits[i]});
            repeat (16) @(posedge pclk);
        end
    endtask
    // Reset, send in modes 2, 1 and 3, then receive good and faulty frames.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h74, 8'h00);
        apb(1'b0, 8'h00, 8'h00);
        check({31'h0, err}, 32'h1);
        apb(1'b1, 8'hcc, 8'hff);
        rd(8'hcc, 8'h38);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, 8'hc8, ctl[m]);
            apb(1'b1, 8'hd0, rxs[m]);
            apb(1'b1, 8'hd8, txd[m]);
            expect_tx(txb[m], txn[m]);
            rd(8'h34, 8'h01);
            apb(1'b1, 8'h34, 8'h00);
        end
        apb(1'b1, 8'h74, 8'h01);
        apb(1'b1, 8'hd8, 8'h00);
        expect_tx(11'h600, 11);
        check({31'h0, serial_irq}, 32'h1);
        apb(1'b1, 8'h74, 8'h00);
        check({31'h0, serial_irq}, 32'h0);
        rd(8'h34, 8'h01);
        apb(1'b1, 8'h34, 8'h00);
        apb(1'b1, 8'hc8, 8'h40);
        send(8'h3c, 1'b0, 1'b1);
        rd(8'hd0, 8'h00);
        apb(1'b1, 8'hd0, 8'h61);
        send(8'h3c, 1'b0, 1'b1);
        rd(8'hd0, 8'h63);
        rd(8'hd4, 8'h3c);
        rd(8'hd0, 8'h61);
        send(8'h3c, 1'b1, 1'b1);
        rd(8'hd0, 8'h73);
        rd(8'h34, 8'h06);
        rd(8'hd4, 8'h3c);
        apb(1'b1, 8'hd0, 8'h61);
        apb(1'b1, 8'h34, 8'h00);
        send(8'h81, 1'b0, 1'b0);
        rd(8'hd0, 8'h67);
        send(8'h42, 1'b0, 1'b1);
        rd(8'hd0, 8'h6f);
        rd(8'hd4, 8'h81);
        tally_and_finish;
    end
endmodule // test_async_serial_transceiver

// ---- uart_checker_asserts.sv ----
// Purpose: Port checks of the serial transceiver.
// Assumes: One clock, async active-low reset.
// Notes: A bit lasts at least 16 clocks.
`timescale 1ns/1ps
module uart_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_tx,
    input wire logic serial_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Mapped words, and a write that masks every source off.
    wire logic hit = paddr inside {8'h34, 8'h74, 8'hc8, 8'hcc, 8'hd0, 8'hd4, 8'hd8};
    wire logic moff = psel && penable && pready && pwrite && paddr == 8'h74 && pwdata[2:0] == 3'h0;
    a_idle_at_reset: assert property ($rose(presetn) |-> serial_tx) else $error("idle");
    a_low_bit_len: assert property ($fell(serial_tx) |-> !serial_tx[*8]) else $error("low");
    a_high_len: assert property ($rose(serial_tx) |-> serial_tx[*8]) else $error("high");
    a_mask_quiets_irq: assert property (moff |-> ##2 !serial_irq) else $error("irq");
    a_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("w");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pulse");
    a_refuse_unmapped: assert property (pready |-> pslverr == !hit) else $error("err");
    a_read_clean: assert property (pready && pslverr |-> !prdata) else $error("hi");
endmodule // uart_checker

bind async_serial_transceiver uart_checker u_checker (.*);

// ---- uart_pkg.sv ----
// Purpose: Types shared by the serial transceiver modules.
// Assumes: Field widths match the constants header.
// Notes: Each design module keeps all of its state in one of the structs below.
package uart_pkg;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_phase_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_phase_t;

    typedef struct packed {
        logic [7:0] irq_flags;
        logic [7:0] irq_mask;
        logic [7:0] tx_ctrl;
        logic [7:0] line_extra;
        logic [7:0] rx_status;
        logic [7:0] rx_data;
        logic [7:0] tx_data;
        logic tx_full;
        tx_phase_t tx_phase;
        logic [8:0] tx_shift;
        logic tx_par;
        logic [3:0] tx_ovs;
        logic [3:0] tx_bit;
        logic tx_line;
        rx_phase_t rx_phase;
        logic [8:0] rx_shift;
        logic rx_par;
        logic [3:0] rx_ovs;
        logic [3:0] rx_bit;
        logic [1:0] rx_votes;
        logic rx_prev;
        logic rx_fresh;
        logic pready;
        logic pslverr;
        logic [7:0] prdata;
        logic irq;
    } uart_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } baud_state_t;

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_t;

endpackage

// ---- uart_regs.svh ----
// Purpose: Register map, field positions, reset values and timing counts of the serial transceiver.
// Assumes: Registers are 8 bits wide; each sits in one aligned 32-bit APB word at four times
//          its index.
// Notes: Definitions only; included by every design file that decodes or builds register fields.
// Operation
// - Idle serial line sits high; a character starts with the line going low.
// - Frame order: low start bit, data LSB first, optional parity, high stop bit.
// - Receiver takes three start-bit samples; two or three zeros accept the start.
// - Mode 1 has 7 data bits, mode 2 has 8; both allow parity; mode 3 never.
// - Transmit and receive run independently and are each double-buffered for gapless streams.
// - With transmit enabled, writing transmit data sets the buffer status bit, then sending starts.
// - Transmitter sends zero start, 7/8/9 data bits LSB first, selected parity, one stop.
// - After the stop bit the transmitter holds the line high until the next start.
// - After the stop bit the transmit-empty interrupt flag is raised.
// - Receive enable bit lets the receiver watch the line and lock to start bits.
// - Received data shifts in LSB first; after parity and stop, buffer full is set.
// - Received ones count must match selected odd or even parity, else parity error.
// - Framing error unless start bit is zero and stop bit is one; the code checks only the stop bit, a bad start is dropped as a glitch.
// - Loading a character while buffer full is still set flags an overrun error.
// - A failed check sets its error flag and the error interrupt flag; software clears.
// - Reading the receive data register clears the buffer full flag.
// - Baud generator drives both directions; a 3-bit field in transmit control selects rate.
`ifndef UART_REGS_SVH
`define UART_REGS_SVH

// Register indices; byte address is four times the index.
`define IDX_IRQ_FLAGS 6'h0d
`define IDX_IRQ_MASK 6'h1d
`define IDX_TX_CONTROL 6'h32
`define IDX_LINE_EXTRA 6'h33
`define IDX_RX_STATUS 6'h34
`define IDX_RX_DATA 6'h35
`define IDX_TX_DATA 6'h36
`define REG_RESET 8'h00

// Transmit control fields.
`define TXC_NINTH 7
`define TXC_MODE_HI 6
`define TXC_MODE_LO 5
`define TXC_BAUD_HI 4
`define TXC_BAUD_LO 2
`define TXC_BUF_STATUS 1
`define TXC_ENABLE 0
// Line control extra fields (stored only).
`define LCX_WRITE_MASK 8'h38

// Receive status fields.
`define RXS_NINTH 7
`define RXS_EVEN 6
`define RXS_PAR_EN 5
`define RXS_PAR_ERR 4
`define RXS_OVR_ERR 3
`define RXS_FRM_ERR 2
`define RXS_FULL 1
`define RXS_ENABLE 0

// Interrupt flag and mask fields.
`define IRQ_ERR 2
`define IRQ_RX_FULL 1
`define IRQ_TX_EMPTY 0
`define IRQ_USED_MASK 8'h07

// Frame modes and data bit counts.
`define MODE_7BIT 2'h1
`define MODE_9BIT 2'h3
`define LAST_BIT_7 4'h6
`define LAST_BIT_8 4'h7
`define LAST_BIT_9 4'h8

// Sixteen ticks per bit; three votes around the middle of the bit.
`define OVS_RATE 16
`define OVS_LAST 4'hf
`define OVS_VOTE_A 4'h7
`define OVS_VOTE_B 4'h8
`define OVS_VOTE_C 4'h9
`define VOTE_MAJORITY 2'h2

// Clock and fastest baud rate; select code k divides that rate by two to the k.
`define SYS_CLK_HZ 100000000
`define FASTEST_BAUD 115200

`endif
